//--- inc/jbs_pkg.sv
// shared constants, cell map and types of the boundary-scan test port
package jbs_pkg;

    // core master clock as specified for the device; the bench runs mclk_in slower
    localparam real JBS_MCLK_MHZ = 35.328;
    // link test clock period in the bench, and the resulting mclk cycles per tck period
    localparam int JBS_MCLK_NS = 100;
    localparam int JBS_TCK_NS = 800;
    localparam int JBS_TCK_MCLK = JBS_TCK_NS / JBS_MCLK_NS;

    // number of boundary cells between serial in and serial out
    localparam int JBS_CELLS = 91;
    localparam int JBS_IR_W = 4;

    // instruction codes and the fixed ir capture pattern
    localparam logic [3:0] JBS_IR_EXTEST = 4'h0;
    localparam logic [3:0] JBS_IR_SAMPLE = 4'h1;
    localparam logic [3:0] JBS_IR_BYPASS = 4'hf;
    localparam logic [3:0] JBS_IR_CAPTURE = 4'h1;
    localparam logic [3:0] JBS_IR_RESET = JBS_IR_BYPASS;

    // b = bidirectional, i = input, o = output, c = clock pin observed as input
    typedef enum logic [1:0] {JBS_B, JBS_I, JBS_O, JBS_C} jbs_cell_t;

    // index 0 sits next to serial in, index JBS_CELLS-1 next to serial out
    localparam jbs_cell_t JBS_CELL_MAP [JBS_CELLS] = '{
        JBS_B, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B,
        JBS_B, JBS_B, JBS_B, JBS_C, JBS_B, JBS_B, JBS_B, JBS_I, JBS_C, JBS_I,
        JBS_I, JBS_B, JBS_I, JBS_O, JBS_I, JBS_B, JBS_B, JBS_B, JBS_B, JBS_B,
        JBS_B, JBS_B, JBS_B, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I,
        JBS_O, JBS_I, JBS_C, JBS_I, JBS_O, JBS_I, JBS_C, JBS_I, JBS_O, JBS_I,
        JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I,
        JBS_I, JBS_I, JBS_I, JBS_O, JBS_O, JBS_O, JBS_O, JBS_O, JBS_O, JBS_O,
        JBS_O, JBS_O, JBS_I, JBS_I, JBS_I, JBS_I, JBS_O, JBS_O, JBS_O, JBS_C,
        JBS_O, JBS_O, JBS_I, JBS_I, JBS_I, JBS_I, JBS_I, JBS_C, JBS_O, JBS_I,
        JBS_C
    };

    // first index of each pin group in the chain
    localparam int JBS_IDX_HOST_AD = 0;
    localparam int JBS_IDX_HOST_INT = 23;
    localparam int JBS_IDX_HW_RESET = 24;
    localparam int JBS_IDX_RX_DATA = 25;
    localparam int JBS_IDX_RX_ADDR = 33;
    localparam int JBS_IDX_TX_DATA = 50;
    localparam int JBS_IDX_TX_ADDR = 58;
    localparam int JBS_IDX_GENERAL_OUT = 80;
    localparam int JBS_IDX_PDOWN = 81;
    localparam int JBS_IDX_FE_RX = 82;
    localparam int JBS_IDX_FE_WORD = 86;

    typedef enum logic [3:0] {
        JBS_TLR, JBS_RTI,
        JBS_SEL_DR, JBS_CAP_DR, JBS_SH_DR, JBS_EX1_DR, JBS_PA_DR, JBS_EX2_DR, JBS_UPD_DR,
        JBS_SEL_IR, JBS_CAP_IR, JBS_SH_IR, JBS_EX1_IR, JBS_PA_IR, JBS_EX2_IR, JBS_UPD_IR
    } jbs_tap_state_t;

    typedef logic [JBS_CELLS-1:0] jbs_chain_t;

    // value and output enable of a group of pads
    typedef struct packed {
        jbs_chain_t val;
        jbs_chain_t oe;
    } jbs_pad_t;

endpackage

//--- logic/jbs_tap_fsm.sv
// test access port controller state machine, stepped on each detected test clock rise
`timescale 1ns/1ps
module jbs_tap_fsm
    import jbs_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // test clock edge and mode select, both already synchronised
    input wire logic tck_rise_in,
    input wire logic tms_in,
    // controller state
    output jbs_tap_state_t state_out
);

    jbs_tap_state_t state_ff;
    jbs_tap_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            JBS_TLR: nxt_state = tms_in ? JBS_TLR : JBS_RTI;
            JBS_RTI: nxt_state = tms_in ? JBS_SEL_DR : JBS_RTI;
            JBS_SEL_DR: nxt_state = tms_in ? JBS_SEL_IR : JBS_CAP_DR;
            JBS_CAP_DR: nxt_state = tms_in ? JBS_EX1_DR : JBS_SH_DR;
            JBS_SH_DR: nxt_state = tms_in ? JBS_EX1_DR : JBS_SH_DR;
            JBS_EX1_DR: nxt_state = tms_in ? JBS_UPD_DR : JBS_PA_DR;
            JBS_PA_DR: nxt_state = tms_in ? JBS_EX2_DR : JBS_PA_DR;
            JBS_EX2_DR: nxt_state = tms_in ? JBS_UPD_DR : JBS_SH_DR;
            JBS_UPD_DR: nxt_state = tms_in ? JBS_SEL_DR : JBS_RTI;
            JBS_SEL_IR: nxt_state = tms_in ? JBS_TLR : JBS_CAP_IR;
            JBS_CAP_IR: nxt_state = tms_in ? JBS_EX1_IR : JBS_SH_IR;
            JBS_SH_IR: nxt_state = tms_in ? JBS_EX1_IR : JBS_SH_IR;
            JBS_EX1_IR: nxt_state = tms_in ? JBS_UPD_IR : JBS_PA_IR;
            JBS_PA_IR: nxt_state = tms_in ? JBS_EX2_IR : JBS_PA_IR;
            JBS_EX2_IR: nxt_state = tms_in ? JBS_UPD_IR : JBS_SH_IR;
            JBS_UPD_IR: nxt_state = tms_in ? JBS_SEL_DR : JBS_RTI;
            default: nxt_state = JBS_TLR;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_ff <= JBS_TLR;
        end else if (tck_rise_in) begin
            state_ff <= nxt_state;
        end
    end

    assign state_out = state_ff;

endmodule

//--- logic/jbs_scan_port.sv
// boundary-scan test access port with the device pin cell chain
// Operation
// - port has serial in, serial out, test clock, mode select and low-active test reset
// - test reset held low puts the controller back into its reset state
// - the port reaches a boundary chain over the pins for chip and board tests
// - core logic runs from the master clock, nominally 35.328MHz from an oscillator
// - utopia receive and transmit clocks are asynchronous to the master clock
// - host bus clock is treated as asynchronous to the master clock
// - eight utopia receive data lines get bidirectional cells, ascending bit order
// - eight utopia transmit data lines get input cells, descending bit order
// - receive address inputs ascending, transmit address inputs descending, all input cells
// - the test port pins themselves have no cells
// - four front-end receive inputs then the word-framing input get input cells
// - the four front-end transmit outputs have no cells
// - general output pin and power-down output each get an output cell
`timescale 1ns/1ps
module jbs_scan_port
    import jbs_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // test access port
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic test_port_reset_n_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // pad side of the chain
    input wire jbs_chain_t pad_in,
    output jbs_pad_t pad_out,
    // core side of the chain
    input wire jbs_pad_t core_in,
    output jbs_chain_t core_rx_out
);

    // pin synchronisers; stage one is read only by stage two
    logic tck_meta_ff;
    logic tck_sync_ff;
    logic tck_prev_ff;
    logic tms_meta_ff;
    logic tms_sync_ff;
    logic tdi_meta_ff;
    logic tdi_sync_ff;
    logic trst_n_meta_ff;
    logic trst_n_sync_ff;
    jbs_chain_t pad_meta_ff;
    jbs_chain_t pad_sync_ff;

    logic tck_rise;
    logic tck_fall;
    logic tap_rst;
    jbs_tap_state_t tap_state;

    logic [JBS_IR_W-1:0] ir_shift_ff;
    logic [JBS_IR_W-1:0] ir_ff;
    logic bypass_ff;
    jbs_chain_t bsr_shift_ff;
    jbs_chain_t bsr_upd_ff;
    jbs_chain_t bsr_capture;
    logic tdo_ff;
    logic tdo_oe_ff;
    jbs_pad_t pad_ff;
    jbs_pad_t nxt_pad;
    jbs_chain_t core_rx_ff;

    logic sel_extest;
    logic sel_bsr;
    logic nxt_tdo;

    // the test clock is slow against mclk, so it is sampled and its edges found here
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tck_meta_ff <= 1'b0;
            tck_sync_ff <= 1'b0;
            tck_prev_ff <= 1'b0;
            tms_meta_ff <= 1'b1;
            tms_sync_ff <= 1'b1;
            tdi_meta_ff <= 1'b1;
            tdi_sync_ff <= 1'b1;
        end else begin
            tck_meta_ff <= tck_in;
            tck_sync_ff <= tck_meta_ff;
            tck_prev_ff <= tck_sync_ff;
            tms_meta_ff <= tms_in;
            tms_sync_ff <= tms_meta_ff;
            tdi_meta_ff <= tdi_in;
            tdi_sync_ff <= tdi_meta_ff;
        end
    end

    // reset comes out held low so the controller starts in its reset state
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            trst_n_meta_ff <= 1'b0;
            trst_n_sync_ff <= 1'b0;
        end else begin
            trst_n_meta_ff <= test_port_reset_n_in;
            trst_n_sync_ff <= trst_n_meta_ff;
        end
    end

    // pads include the utopia and host clock pins, which are unrelated to mclk
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pad_meta_ff <= '0;
            pad_sync_ff <= '0;
        end else begin
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    assign tck_rise = tck_sync_ff & ~tck_prev_ff;
    assign tck_fall = ~tck_sync_ff & tck_prev_ff;
    assign tap_rst = rst_in | ~trst_n_sync_ff;

    jbs_tap_fsm u_fsm (
        .mclk_in(mclk_in),
        .rst_in(tap_rst),
        .tck_rise_in(tck_rise),
        .tms_in(tms_sync_ff),
        .state_out(tap_state)
    );

    assign sel_extest = (ir_ff == JBS_IR_EXTEST);
    assign sel_bsr = sel_extest | (ir_ff == JBS_IR_SAMPLE);

    // per-cell capture source and pad drive, by cell kind
    genvar g;
    generate
        for (g = 0; g < JBS_CELLS; g++) begin : g_cell
            if (JBS_CELL_MAP[g] == JBS_B) begin : g_bidir
                // in extest the pad is always driven; capture still takes the synchronised pad value
                assign bsr_capture[g] = pad_sync_ff[g];
                assign nxt_pad.val[g] = sel_extest ? bsr_upd_ff[g] : core_in.val[g];
                assign nxt_pad.oe[g] = sel_extest ? 1'b1 : core_in.oe[g];
            end else if (JBS_CELL_MAP[g] == JBS_O) begin : g_out
                assign bsr_capture[g] = core_in.val[g];
                assign nxt_pad.val[g] = sel_extest ? bsr_upd_ff[g] : core_in.val[g];
                assign nxt_pad.oe[g] = 1'b1;
            end else begin : g_in
                assign bsr_capture[g] = pad_sync_ff[g];
                assign nxt_pad.val[g] = 1'b0;
                assign nxt_pad.oe[g] = 1'b0;
            end
        end
    endgenerate

    // instruction register; defaults to bypass so functional pins run untouched
    always_ff @(posedge mclk_in) begin
        if (tap_rst) begin
            ir_shift_ff <= JBS_IR_RESET;
            ir_ff <= JBS_IR_RESET;
        end else if (tap_state == JBS_TLR) begin
            ir_ff <= JBS_IR_RESET;
        end else if (tck_rise && tap_state == JBS_CAP_IR) begin
            ir_shift_ff <= JBS_IR_CAPTURE;
        end else if (tck_rise && tap_state == JBS_SH_IR) begin
            ir_shift_ff <= {tdi_sync_ff, ir_shift_ff[JBS_IR_W-1:1]};
        end else if (tck_fall && tap_state == JBS_UPD_IR) begin
            ir_ff <= ir_shift_ff;
        end
    end

    // bypass stage, loaded with zero at capture
    always_ff @(posedge mclk_in) begin
        if (tap_rst) begin
            bypass_ff <= 1'b0;
        end else if (tck_rise && tap_state == JBS_CAP_DR) begin
            bypass_ff <= 1'b0;
        end else if (tck_rise && tap_state == JBS_SH_DR) begin
            bypass_ff <= tdi_sync_ff;
        end
    end

    // boundary chain: serial in enters cell 0, serial out leaves the last cell
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bsr_shift_ff <= '0;
        end else if (tck_rise && sel_bsr && tap_state == JBS_CAP_DR) begin
            bsr_shift_ff <= bsr_capture;
        end else if (tck_rise && sel_bsr && tap_state == JBS_SH_DR) begin
            bsr_shift_ff <= {bsr_shift_ff[JBS_CELLS-2:0], tdi_sync_ff};
        end
    end

    // update latch holds the value driven during extest
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bsr_upd_ff <= '0;
        end else if (tck_fall && sel_bsr && tap_state == JBS_UPD_DR) begin
            bsr_upd_ff <= bsr_shift_ff;
        end
    end

    always_comb begin
        nxt_tdo = bypass_ff;
        if (tap_state == JBS_SH_IR) begin
            nxt_tdo = ir_shift_ff[0];
        end else if (sel_bsr) begin
            nxt_tdo = bsr_shift_ff[JBS_CELLS-1];
        end
    end

    // serial out changes on the falling test clock and is released outside shift states
    always_ff @(posedge mclk_in) begin
        if (tap_rst) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= nxt_tdo;
            tdo_oe_ff <= (tap_state == JBS_SH_DR) || (tap_state == JBS_SH_IR);
        end
    end

    // pad drive and core view are registered; costs one mclk of latency
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pad_ff <= '0;
            core_rx_ff <= '0;
        end else begin
            pad_ff <= nxt_pad;
            core_rx_ff <= pad_sync_ff;
        end
    end

    assign tdo_out = tdo_ff;
    assign tdo_oe_out = tdo_oe_ff;
    assign pad_out = pad_ff;
    assign core_rx_out = core_rx_ff;

endmodule

//--- bench/jbs_scan_port_checker.sv
// concurrent checks on the pins of the boundary-scan test port
`timescale 1ns/1ps
module jbs_scan_port_checker
    import jbs_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // test access port
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic test_port_reset_n_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    // pad and core sides
    input wire jbs_chain_t pad_in,
    input wire jbs_pad_t pad_out,
    input wire jbs_pad_t core_in,
    input wire jbs_chain_t core_rx_out
);
    function automatic jbs_chain_t kind_mask(jbs_cell_t k);
        jbs_chain_t m;
        for (int i = 0; i < JBS_CELLS; i++) begin
            m[i] = (JBS_CELL_MAP[i] == k);
        end
        return m;
    endfunction
    localparam jbs_chain_t O_MASK = kind_mask(JBS_O);
    localparam jbs_chain_t B_MASK = kind_mask(JBS_B);
    localparam jbs_chain_t IN_MASK = ~(O_MASK | B_MASK);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    reset_clear_a: assert property (disable iff (1'b0) rst_in |=>
        !tdo_out && !tdo_oe_out && pad_out == '0 && core_rx_out == '0) else $error("outputs not cleared by reset");
    port_reset_a: assert property (!test_port_reset_n_in [*6] |-> !tdo_out && !tdo_oe_out)
        else $error("test reset left tdo active");
    // tdo may only move a few clocks into a low test clock phase
    tdo_on_fall_a: assert property (disable iff (rst_in || !test_port_reset_n_in)
        $changed(tdo_out) |-> !$past(tck_in, 3)) else $error("tdo moved outside a test clock fall");
    oe_on_fall_a: assert property ($rose(tdo_oe_out) |-> !$past(tck_in, 3) && !$past(tms_in, 6))
        else $error("tdo enable rose without a shift entry");
    pad_sync_a: assert property (!$past(rst_in, 1) && !$past(rst_in, 2) && !$past(rst_in, 3) && !$past(rst_in, 4)
        |-> core_rx_out == $past(pad_in, 3)) else $error("core receive copy wrong");
    input_hiz_a: assert property ((pad_out.oe & IN_MASK) == '0) else $error("input cell pad driven");
    out_enable_a: assert property (!$past(rst_in) |-> (pad_out.oe & O_MASK) == O_MASK)
        else $error("output cell pad not enabled");
    func_mode_a: assert property (!test_port_reset_n_in [*6] |->
        ((pad_out.val ^ $past(core_in.val)) & (O_MASK | B_MASK)) == '0 &&
        (pad_out.oe & B_MASK) == ($past(core_in.oe) & B_MASK)) else $error("pads not functional in test reset");
    cover property ($rose(tdo_oe_out));
    cover property (!test_port_reset_n_in [*6]);
    cover property ($rose(pad_out.oe[0]));
endmodule

bind jbs_scan_port jbs_scan_port_checker jbs_scan_port_checker_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .test_port_reset_n_in(test_port_reset_n_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pad_in(pad_in), .pad_out(pad_out), .core_in(core_in),
    .core_rx_out(core_rx_out));

//--- bench/jbs_tester.sv
// board tester model driving the test access port
`timescale 1ns/1ps
module jbs_tester
    import jbs_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // test access port
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic port_reset_n_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        port_reset_n_out = 1'b1;
    end
    // one 8-clock test period; tck rests low between calls so it stands still outside frames
    task automatic step(input logic m, input logic d, output logic o);
        tms_out <= m;
        tdi_out <= d;
        repeat (JBS_TCK_MCLK / 2) @(posedge mclk_in);
        tck_out <= 1'b1;
        repeat (JBS_TCK_MCLK / 4) @(posedge mclk_in);
        @(negedge mclk_in);
        // read mid high phase, far from the fall that launches the next bit;
        // a released line floats to its pull-up level, so a missing enable shows as ones
        o = tdo_oe_in ? tdo_in : 1'b1;
        repeat (JBS_TCK_MCLK / 4) @(posedge mclk_in);
        tck_out <= 1'b0;
    endtask
    task automatic port_reset();
        port_reset_n_out <= 1'b0;
        repeat (8) @(posedge mclk_in);
        port_reset_n_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule

//--- bench/test_jbs_scan_port.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module test_jbs_scan_port
    import jbs_pkg::*;
;
    logic mclk_in, rst_in, tck, tms, tdi, port_reset_n, tdo_out, tdo_oe_out, o;
    jbs_chain_t pad_in, core_rx_out, got, pat, bmask, omask;
    jbs_pad_t core_in, pad_out;
    logic [31:0] seed = 32'h0e98_80ef;
    int failures = 0;
    int total_checks = 0;
    jbs_tester jbs_tester_inst (.mclk_in(mclk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .port_reset_n_out(port_reset_n), .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
    jbs_scan_port jbs_scan_port_inst (.mclk_in(mclk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .test_port_reset_n_in(port_reset_n), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pad_in(pad_in),
        .pad_out(pad_out), .core_in(core_in), .core_rx_out(core_rx_out));
    initial begin
        mclk_in = 1'b0;
        forever #(JBS_MCLK_NS / 2) mclk_in = ~mclk_in;
    end
    function automatic jbs_chain_t mask(jbs_cell_t k);
        jbs_chain_t m;
        for (int i = 0; i < JBS_CELLS; i++) begin
            m[i] = (JBS_CELL_MAP[i] == k);
        end
        return m;
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic jbs_chain_t rchain();
        logic [95:0] w;
        w = {rnd(), rnd(), rnd()};
        return w[90:0];
    endfunction
    // a capture loads the observed pad, except output cells which take the core value
    function automatic jbs_chain_t cap_exp();
        return (pad_in & ~omask) | (core_in.val & omask);
    endfunction
    task automatic chk(string n, jbs_chain_t s, jbs_chain_t e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // from idle: select, capture, shift n bits, update, idle; ir is lsb first, dr cell 90 first
    task automatic scan(logic ir, int n, jbs_chain_t din, output jbs_chain_t dout);
        logic b;
        jbs_tester_inst.step(1'b1, 1'b0, b);
        if (ir) jbs_tester_inst.step(1'b1, 1'b0, b);
        jbs_tester_inst.step(1'b0, 1'b0, b);
        jbs_tester_inst.step(1'b0, 1'b0, b);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            jbs_tester_inst.step(i == n - 1, din[ir ? i : n - 1 - i], b);
            dout[ir ? i : n - 1 - i] = b;
        end
        jbs_tester_inst.step(1'b1, 1'b0, b);
        jbs_tester_inst.step(1'b0, 1'b0, b);
    endtask
    task automatic load_ir(logic [3:0] code);
        scan(1'b1, 4, jbs_chain_t'(code), got);
        chk("ir capture", got, jbs_chain_t'(JBS_IR_CAPTURE));
    endtask
    task automatic bypass_check();
        logic q[$];
        jbs_chain_t e;
        pat = jbs_chain_t'(rnd());
        scan(1'b0, 8, pat, got);
        // one-stage model: the captured zero leaves first, every bit then comes out one shift late
        q.push_back(1'b0);
        e = '0;
        for (int i = 0; i < 8; i++) begin
            q.push_back(pat[7 - i]);
            e[7 - i] = q.pop_front();
        end
        chk("bypass", got, e);
    endtask
    task automatic new_pads();
        pad_in <= rchain();
        core_in <= {rchain(), rchain()};
        repeat (4) @(posedge mclk_in);
    endtask
    task automatic func_check();
        chk("func val", pad_out.val & (bmask | omask), core_in.val & (bmask | omask));
        chk("func oe", pad_out.oe, (core_in.oe & bmask) | omask);
    endtask
    initial begin
        rst_in = 1'b1;
        pad_in = '0;
        core_in = '0;
        bmask = mask(JBS_B);
        omask = mask(JBS_O);
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        chk("reset out", jbs_chain_t'({tdo_out, tdo_oe_out}) | pad_out.oe | core_rx_out, '0);
        repeat (4) @(posedge mclk_in);
        repeat (5) jbs_tester_inst.step(1'b1, 1'b0, o);
        jbs_tester_inst.step(1'b0, 1'b0, o);
        load_ir(JBS_IR_BYPASS);
        bypass_check();
        new_pads();
        func_check();
        chk("core rx", core_rx_out, pad_in);
        load_ir(JBS_IR_SAMPLE);
        pat = rchain();
        scan(1'b0, JBS_CELLS, pat, got);
        chk("sample capture", got, cap_exp());
        func_check();
        // the preloaded pattern must reach the pads as soon as extest is in
        load_ir(JBS_IR_EXTEST);
        chk("extest drive", pad_out.val & (bmask | omask), pat & (bmask | omask));
        chk("extest oe", pad_out.oe, bmask | omask);
        new_pads();
        pat = rchain();
        scan(1'b0, JBS_CELLS, pat, got);
        chk("extest capture", got, cap_exp());
        chk("extest update", pad_out.val & (bmask | omask), pat & (bmask | omask));
        jbs_tester_inst.port_reset();
        func_check();
        chk("port reset tdo", jbs_chain_t'({tdo_out, tdo_oe_out}), '0);
        jbs_tester_inst.step(1'b0, 1'b0, o);
        load_ir(4'h5);
        bypass_check();
        func_check();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        results();
    end
endmodule
